// file: pkg/ctu_pkg.sv
// constants and types for the control transfer unit
package ctu_pkg;

  // --------------------------------------------------------------
  // transfer operations
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    CTU_OP_NONE,
    CTU_OP_JMP_REL,
    CTU_OP_JMP_REG,
    CTU_OP_JMP_MEM,
    CTU_OP_JMP_FAR_DIR,
    CTU_OP_JMP_FAR_MEM,
    CTU_OP_CALL_REL,
    CTU_OP_CALL_REG,
    CTU_OP_CALL_MEM,
    CTU_OP_CALL_FAR_DIR,
    CTU_OP_CALL_FAR_MEM,
    CTU_OP_RET_NEAR,
    CTU_OP_RET_FAR,
    CTU_OP_INTERRUPT_RETURN
  } ctu_op_t;

  // --------------------------------------------------------------
  // descriptor kinds named by a far selector
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    CTU_DESC_CODE,
    CTU_DESC_CALL_GATE,
    CTU_DESC_TASK_GATE,
    CTU_DESC_TSS
  } ctu_desc_t;

  // --------------------------------------------------------------
  // register map (word index; byte address = index * 4)
  // --------------------------------------------------------------
  localparam logic [3:0] CTU_IDX_CTRL = 4'h0;
  localparam logic [3:0] CTU_IDX_OP = 4'h1;
  localparam logic [3:0] CTU_IDX_DISP = 4'h2;
  localparam logic [3:0] CTU_IDX_FAR = 4'h3;
  localparam logic [3:0] CTU_IDX_REGVAL = 4'h4;
  localparam logic [3:0] CTU_IDX_MEMADDR = 4'h5;
  localparam logic [3:0] CTU_IDX_GATE = 4'h6;
  localparam logic [3:0] CTU_IDX_TASK = 4'h7;
  localparam logic [3:0] CTU_IDX_IPCS = 4'h8;
  localparam logic [3:0] CTU_IDX_SP = 4'h9;
  localparam logic [3:0] CTU_IDX_STATUS = 4'hA;
  localparam logic [3:0] CTU_IDX_LINK = 4'hB;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int CTU_CTRL_GO_BIT = 0;
  localparam int CTU_CTRL_PMODE_BIT = 1;
  localparam int CTU_CTRL_NT_BIT = 2;
  localparam int CTU_OP_DISP8_BIT = 4;
  localparam int CTU_OP_DESC_LSB = 8;
  localparam int CTU_OP_SAMEPL_BIT = 10;
  localparam int CTU_ST_BUSY_BIT = 0;
  localparam int CTU_ST_FAULT_BIT = 1;
  localparam int CTU_ST_TSW_BIT = 2;

  // --------------------------------------------------------------
  // reset values and stack word step
  // --------------------------------------------------------------
  localparam logic [15:0] CTU_RST_IP = 16'h0000;
  localparam logic [15:0] CTU_RST_CS = 16'h0000;
  localparam logic [15:0] CTU_RST_SP = 16'h0000;
  localparam logic [15:0] CTU_WORD_STEP = 16'h0002;
  localparam logic [31:0] CTU_UNMAPPED = 32'h0000_0000;

endpackage : ctu_pkg

// file: rtl/ctu_core.sv
// control transfer unit: jumps, calls and returns with stack access
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [R1] jump writes no stack, keeps no return
// [R2] near displacement: 16 bits or sign-extended 8
// [R3] near target: displacement plus next pointer
// [R4] register jump copies register to pointer
// [R5] memory jump reads indexed word pointer
// [R6] direct far: selector to segment, offset to pointer
// [R7] indirect far: low word offset, next selector
// [R8] call gate replaces supplied target
// [R9] far jump only to same privilege
// [R10] gates and task segments only in protected mode
// [R11] indirect far may name task gate or segment
// [R12] call pushes return pointer, far also segment
// [R13] task call links old task, sets nested flag
// [R14] return pops pointer, far return also segment
// [R15] return constant added to stack after pops
// [R16] software gives even return constant
// [R17] nested interrupt return goes to linked task
// [R18] far call pushes segment before pointer
module ctu_core (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // avalon-mm register slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // memory master, one word per access
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  input wire logic [15:0] mem_rdata_i,
  input wire logic mem_ack_i,
  // resulting program state
  output logic [15:0] instruction_pointer_o,
  output logic [15:0] code_seg_o,
  output logic [15:0] stack_top_pointer_o,
  output logic nested_task_flag_o,
  output logic busy_o
);

  typedef enum logic [2:0] {
    CTU_S_IDLE,
    CTU_S_RD0,
    CTU_S_RD1,
    CTU_S_PUSH0,
    CTU_S_PUSH1,
    CTU_S_POP0,
    CTU_S_POP1,
    CTU_S_LINK
  } ctu_state_t;

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  ctu_state_t state_reg;
  logic go_reg;
  logic pmode_reg;
  logic nt_reg;
  logic [15:0] op_reg;
  logic [15:0] disp_reg;
  logic [31:0] far_reg;
  logic [15:0] regval_reg;
  logic [15:0] memaddr_reg;
  logic [31:0] gate_reg;
  logic [31:0] task_reg;
  logic [15:0] ip_reg;
  logic [15:0] cs_reg;
  logic [15:0] sp_reg;
  logic fault_reg;
  logic tsw_reg;
  logic [15:0] link_reg;
  logic [15:0] imm_reg;
  logic [15:0] new_ip_reg;
  logic [15:0] new_cs_reg;
  logic [31:0] rdata_reg;
  logic wait_reg;

  ctu_pkg::ctu_op_t op_code;
  ctu_pkg::ctu_desc_t desc;
  logic is_far_mem;
  logic is_call;
  logic is_far;
  logic [15:0] disp_ext;

  // sign-extend a byte
  function automatic logic [15:0] ctu_sext8(input logic [7:0] v);
    ctu_sext8 = {{8{v[7]}}, v};
  endfunction : ctu_sext8

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  assign op_code = ctu_pkg::ctu_op_t'(op_reg[3:0]);
  assign desc = ctu_pkg::ctu_desc_t'(
    op_reg[ctu_pkg::CTU_OP_DESC_LSB +: 2]);
  assign is_far_mem = (op_code == ctu_pkg::CTU_OP_JMP_FAR_MEM) ||
                      (op_code == ctu_pkg::CTU_OP_CALL_FAR_MEM);
  assign is_far = is_far_mem || (op_code == ctu_pkg::CTU_OP_JMP_FAR_DIR) ||
                  (op_code == ctu_pkg::CTU_OP_CALL_FAR_DIR);
  assign is_call = op_code inside {[ctu_pkg::CTU_OP_CALL_REL :
                                    ctu_pkg::CTU_OP_CALL_FAR_MEM]};
  // [R2] displacement width
  assign disp_ext = op_reg[ctu_pkg::CTU_OP_DISP8_BIT] ?
                    ctu_sext8(disp_reg[7:0]) : disp_reg;

  // --------------------------------------------------------------
  // avalon slave: one wait cycle, then answer
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      wait_reg <= 1'b1;
    else if ((avs_read_i || avs_write_i) && wait_reg)
      wait_reg <= 1'b0;
    else
      wait_reg <= 1'b1;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_reg <= ctu_pkg::CTU_UNMAPPED;
    else if (avs_read_i && wait_reg)
    begin
      unique case (avs_address_i)
        ctu_pkg::CTU_IDX_CTRL:
          rdata_reg <= {29'h0000_0000, nt_reg, pmode_reg, go_reg};
        ctu_pkg::CTU_IDX_OP: rdata_reg <= 32'(op_reg);
        ctu_pkg::CTU_IDX_DISP: rdata_reg <= 32'(disp_reg);
        ctu_pkg::CTU_IDX_FAR: rdata_reg <= far_reg;
        ctu_pkg::CTU_IDX_REGVAL: rdata_reg <= 32'(regval_reg);
        ctu_pkg::CTU_IDX_MEMADDR: rdata_reg <= 32'(memaddr_reg);
        ctu_pkg::CTU_IDX_GATE: rdata_reg <= gate_reg;
        ctu_pkg::CTU_IDX_TASK: rdata_reg <= task_reg;
        ctu_pkg::CTU_IDX_IPCS: rdata_reg <= {cs_reg, ip_reg};
        ctu_pkg::CTU_IDX_SP: rdata_reg <= {imm_reg, sp_reg};
        ctu_pkg::CTU_IDX_STATUS:
          rdata_reg <= {29'h0000_0000, tsw_reg, fault_reg,
                        state_reg != CTU_S_IDLE};
        ctu_pkg::CTU_IDX_LINK: rdata_reg <= 32'(link_reg);
        default: rdata_reg <= ctu_pkg::CTU_UNMAPPED;
      endcase
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;

  // configuration written by software, ignored while busy
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      op_reg <= 16'h0000;
      disp_reg <= 16'h0000;
      far_reg <= 32'h0000_0000;
      regval_reg <= 16'h0000;
      memaddr_reg <= 16'h0000;
      gate_reg <= 32'h0000_0000;
      task_reg <= 32'h0000_0000;
      pmode_reg <= 1'b0;
      imm_reg <= 16'h0000;
    end
    else if (avs_write_i && !wait_reg && state_reg == CTU_S_IDLE)
    begin
      unique case (avs_address_i)
        ctu_pkg::CTU_IDX_CTRL:
          pmode_reg <= avs_writedata_i[ctu_pkg::CTU_CTRL_PMODE_BIT];
        ctu_pkg::CTU_IDX_OP: op_reg <= avs_writedata_i[15:0];
        ctu_pkg::CTU_IDX_DISP: disp_reg <= avs_writedata_i[15:0];
        ctu_pkg::CTU_IDX_FAR: far_reg <= avs_writedata_i;
        ctu_pkg::CTU_IDX_REGVAL: regval_reg <= avs_writedata_i[15:0];
        ctu_pkg::CTU_IDX_MEMADDR: memaddr_reg <= avs_writedata_i[15:0];
        ctu_pkg::CTU_IDX_GATE: gate_reg <= avs_writedata_i;
        ctu_pkg::CTU_IDX_TASK: task_reg <= avs_writedata_i;
        ctu_pkg::CTU_IDX_SP: imm_reg <= avs_writedata_i[31:16];
        default: imm_reg <= imm_reg;
      endcase
    end
  end

  // go is a one-cycle start pulse
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      go_reg <= 1'b0;
    else
      go_reg <= avs_write_i && !wait_reg && state_reg == CTU_S_IDLE &&
                avs_address_i == ctu_pkg::CTU_IDX_CTRL &&
                avs_writedata_i[ctu_pkg::CTU_CTRL_GO_BIT];
  end

  // --------------------------------------------------------------
  // transfer sequencer
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= CTU_S_IDLE;
      ip_reg <= ctu_pkg::CTU_RST_IP;
      cs_reg <= ctu_pkg::CTU_RST_CS;
      sp_reg <= ctu_pkg::CTU_RST_SP;
      nt_reg <= 1'b0;
      fault_reg <= 1'b0;
      tsw_reg <= 1'b0;
      link_reg <= 16'h0000;
      new_ip_reg <= 16'h0000;
      new_cs_reg <= 16'h0000;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 16'h0000;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        CTU_S_IDLE:
        begin
          if (go_reg)
          begin
            fault_reg <= 1'b0;
            tsw_reg <= 1'b0;
            new_cs_reg <= cs_reg;
            unique case (op_code)
              // [R1] [R3] relative target, push only for call
              ctu_pkg::CTU_OP_JMP_REL, ctu_pkg::CTU_OP_CALL_REL:
              begin
                new_ip_reg <= ip_reg + disp_ext;
                state_reg <= is_call ? CTU_S_PUSH1 : CTU_S_LINK;
              end
              // [R4] register target
              ctu_pkg::CTU_OP_JMP_REG, ctu_pkg::CTU_OP_CALL_REG:
              begin
                new_ip_reg <= regval_reg;
                state_reg <= is_call ? CTU_S_PUSH1 : CTU_S_LINK;
              end
              // [R5] indexed word pointer fetch
              ctu_pkg::CTU_OP_JMP_MEM, ctu_pkg::CTU_OP_CALL_MEM,
              ctu_pkg::CTU_OP_JMP_FAR_MEM, ctu_pkg::CTU_OP_CALL_FAR_MEM:
              begin
                mem_addr_o <= memaddr_reg;
                mem_rd_o <= 1'b1;
                state_reg <= CTU_S_RD0;
              end
              // [R6] far pointer from instruction
              ctu_pkg::CTU_OP_JMP_FAR_DIR, ctu_pkg::CTU_OP_CALL_FAR_DIR:
              begin
                new_ip_reg <= far_reg[15:0];
                new_cs_reg <= far_reg[31:16];
                state_reg <= CTU_S_RD1;
              end
              // [R14] [R17] pop pointer, or back to linked task
              ctu_pkg::CTU_OP_RET_NEAR, ctu_pkg::CTU_OP_RET_FAR,
              ctu_pkg::CTU_OP_INTERRUPT_RETURN:
                if (op_code == ctu_pkg::CTU_OP_INTERRUPT_RETURN && nt_reg)
                begin
                  new_ip_reg <= ip_reg;
                  new_cs_reg <= link_reg;
                  nt_reg <= 1'b0;
                  tsw_reg <= 1'b1;
                  state_reg <= CTU_S_LINK;
                end
                else
                begin
                  mem_addr_o <= sp_reg;
                  mem_rd_o <= 1'b1;
                  state_reg <= CTU_S_POP0;
                end
              default: fault_reg <= 1'b0;
            endcase
          end
        end
        // [R7] lower word is offset
        CTU_S_RD0:
          if (mem_ack_i)
          begin
            new_ip_reg <= mem_rdata_i;
            mem_addr_o <= mem_addr_o + ctu_pkg::CTU_WORD_STEP;
            if (is_far_mem)
              state_reg <= CTU_S_RD1;
            else
            begin
              mem_rd_o <= 1'b0;
              if (is_call)
                state_reg <= CTU_S_PUSH1;
              else
              begin
                ip_reg <= mem_rdata_i;
                state_reg <= CTU_S_IDLE;
              end
            end
          end
        // far target resolution
        CTU_S_RD1:
          if (mem_ack_i || !is_far_mem)
          begin
            mem_rd_o <= 1'b0;
            if (is_far_mem)
              new_cs_reg <= mem_rdata_i;
            // [R10] [R11] gates and task segments need protected mode
            if (desc != ctu_pkg::CTU_DESC_CODE && !pmode_reg)
            begin
              fault_reg <= 1'b1;
              state_reg <= CTU_S_IDLE;
            end
            // [R8] call gate supplies segment and pointer
            else if (desc == ctu_pkg::CTU_DESC_CALL_GATE)
            begin
              new_ip_reg <= gate_reg[15:0];
              new_cs_reg <= gate_reg[31:16];
              state_reg <= is_call ? CTU_S_PUSH0 : CTU_S_LINK;
            end
            // [R11] task gate or task segment
            else if (desc != ctu_pkg::CTU_DESC_CODE)
            begin
              new_ip_reg <= task_reg[15:0];
              new_cs_reg <= task_reg[31:16];
              tsw_reg <= 1'b1;
              state_reg <= CTU_S_LINK;
            end
            // [R9] same privilege level only
            else if (!op_reg[ctu_pkg::CTU_OP_SAMEPL_BIT])
            begin
              fault_reg <= 1'b1;
              state_reg <= CTU_S_IDLE;
            end
            else
              state_reg <= is_call ? CTU_S_PUSH0 : CTU_S_LINK;
          end
        // [R12] [R18] segment pushed first, then pointer
        CTU_S_PUSH0, CTU_S_PUSH1:
          if (!mem_wr_o)
          begin
            mem_addr_o <= sp_reg - ctu_pkg::CTU_WORD_STEP;
            mem_wdata_o <= (state_reg == CTU_S_PUSH0) ? cs_reg : ip_reg;
            mem_wr_o <= 1'b1;
          end
          else if (mem_ack_i)
          begin
            mem_wr_o <= 1'b0;
            sp_reg <= sp_reg - ctu_pkg::CTU_WORD_STEP;
            if (state_reg == CTU_S_PUSH0)
              state_reg <= CTU_S_PUSH1;
            else
            begin
              ip_reg <= new_ip_reg;
              cs_reg <= new_cs_reg;
              state_reg <= CTU_S_IDLE;
            end
          end
        // [R14] pointer popped
        CTU_S_POP0:
          if (mem_ack_i)
          begin
            ip_reg <= mem_rdata_i;
            mem_addr_o <= sp_reg + ctu_pkg::CTU_WORD_STEP;
            if (op_code == ctu_pkg::CTU_OP_RET_NEAR)
            begin
              mem_rd_o <= 1'b0;
              // [R15] release caller arguments
              sp_reg <= sp_reg + ctu_pkg::CTU_WORD_STEP + imm_reg;
              state_reg <= CTU_S_IDLE;
            end
            else
              state_reg <= CTU_S_POP1;
          end
        // [R14] segment popped second
        CTU_S_POP1:
          if (mem_ack_i)
          begin
            mem_rd_o <= 1'b0;
            cs_reg <= mem_rdata_i;
            // [R15] constant added after the pops
            sp_reg <= sp_reg + ctu_pkg::CTU_WORD_STEP +
                      ctu_pkg::CTU_WORD_STEP +
                      ((op_code == ctu_pkg::CTU_OP_RET_FAR) ?
                       imm_reg : 16'h0000);
            state_reg <= CTU_S_IDLE;
          end
        // commit target; task call links tasks
        CTU_S_LINK:
        begin
          ip_reg <= new_ip_reg;
          cs_reg <= new_cs_reg;
          // [R13] link outgoing task, set nested flag
          if (tsw_reg && is_call)
          begin
            link_reg <= cs_reg;
            nt_reg <= 1'b1;
          end
          state_reg <= CTU_S_IDLE;
        end
        default: state_reg <= CTU_S_IDLE;
      endcase
    end
  end

  assign instruction_pointer_o = ip_reg;
  assign code_seg_o = cs_reg;
  assign stack_top_pointer_o = sp_reg;
  assign nested_task_flag_o = nt_reg;
  assign busy_o = state_reg != CTU_S_IDLE;

endmodule : ctu_core

`default_nettype wire

// file: testbench/ctu_core_asserts.sv
// port assertions for the control transfer unit
`timescale 1ns/1ps
`default_nettype none
module ctu_core_asserts (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // register bus
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  // memory
  input wire logic [15:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic mem_ack_i,
  // program state
  input wire logic [15:0] instruction_pointer_o,
  input wire logic [15:0] code_seg_o,
  input wire logic [15:0] stack_top_pointer_o,
  input wire logic nested_task_flag_o,
  input wire logic busy_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ------------------------------------------------------------
  // register bus handshake
  // ------------------------------------------------------------
  a_wait_answer: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
  a_wait_cause: assert property (!avs_waitrequest_o |->
    $past(avs_read_i || avs_write_i)) else $error("answer unasked");
  a_wait_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  // ------------------------------------------------------------
  // memory access
  // ------------------------------------------------------------
  a_rd_hold: assert property (mem_rd_o && !mem_ack_i |=>
    mem_rd_o && $stable(mem_addr_o)) else $error("read dropped early");
  a_wr_hold: assert property (mem_wr_o && !mem_ack_i |=> mem_wr_o &&
    $stable(mem_addr_o) && $stable(mem_wdata_o)) else $error("write moved");
  a_push_gap: assert property (mem_wr_o && mem_ack_i |=> !mem_wr_o)
    else $error("no gap between pushes");
  a_mem_excl: assert property (!(mem_rd_o && mem_wr_o))
    else $error("read and write together");
  a_push_stack: assert property (mem_wr_o |-> 16'(stack_top_pointer_o -
    mem_addr_o) inside {16'h0002, 16'h0004}) else $error("push off stack");
  a_idle_quiet: assert property (!busy_o |-> !mem_rd_o && !mem_wr_o)
    else $error("memory access while idle");
  a_idle_state: assert property (!busy_o && $past(!busy_o) |->
    $stable(instruction_pointer_o) && $stable(code_seg_o) &&
    $stable(stack_top_pointer_o)) else $error("state moved while idle");
  c_push: cover property (mem_wr_o && mem_ack_i);
  c_pair_read: cover property (mem_rd_o && mem_ack_i ##1 mem_rd_o);
  c_nested: cover property ($rose(nested_task_flag_o));
  c_bus_read: cover property (avs_read_i && !avs_waitrequest_o);
endmodule : ctu_core_asserts
`default_nettype wire

// file: testbench/ctu_mem_model.sv
// word memory model on the far side of the transfer unit
`timescale 1ns/1ps
`default_nettype none
module ctu_mem_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // word port
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [3:0] lat_i,
  output logic [15:0] rdata_o,
  output logic ack_o
);
  logic [15:0] mem [0:32767];
  logic [3:0] cnt;
  int wr_cnt;
  // answer after lat_i cycles; data scrambled off ack
  always @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ack_o <= 1'h0;
      cnt <= 4'h0;
      rdata_o <= 16'h5A5A;
      wr_cnt <= 0;
    end
    else if (!ack_o && (rd_i || wr_i) && cnt >= lat_i)
    begin
      ack_o <= 1'h1;
      rdata_o <= wr_i ? ~rdata_o : mem[addr_i[15:1]];
      if (wr_i)
        mem[addr_i[15:1]] <= wdata_i;
      wr_cnt <= wr_cnt + (wr_i ? 1 : 0);
    end
    else
    begin
      ack_o <= 1'h0;
      cnt <= (!ack_o && (rd_i || wr_i)) ? cnt + 4'h1 : 4'h0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule : ctu_mem_model
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the control transfer unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o, rd;
  logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i, ip0, cs0, sp0, tgt;
  logic [15:0] instruction_pointer_o, code_seg_o, stack_top_pointer_o;
  logic avs_waitrequest_o, mem_rd_o, mem_wr_o, mem_ack_i;
  logic nested_task_flag_o, busy_o;
  logic [3:0] lat = 4'h0;
  ctu_pkg::ctu_op_t op;
  int error_cnt = 0;
  int total_checks = 0;
  int i, wc0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  ctu_core ctu_core_i (.sys_clk_i, .nrst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .mem_addr_o, .mem_wdata_o, .mem_rd_o, .mem_wr_o, .mem_rdata_i,
    .mem_ack_i, .instruction_pointer_o, .code_seg_o, .stack_top_pointer_o,
    .nested_task_flag_o, .busy_o);
  ctu_mem_model ctu_mem_model_i (.sys_clk_i, .nrst_i, .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o), .lat_i(lat),
    .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    for (n = 0; n < 100; n++)
    begin
      @(posedge sys_clk_i);
      if (avs_waitrequest_o === 1'h0)
        break;
    end
    if (n == 100)
      error_cnt++;
    rd = avs_readdata_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr

  task automatic rdr(input logic [3:0] a);
    bus(1'h0, a, 32'h0000_0000);
  endtask : rdr

  function automatic logic [31:0] opw(input ctu_pkg::ctu_op_t o,
    input logic [1:0] desc, input logic same);
    return {21'h00000, same, desc, 3'h0, 1'h0, o};
  endfunction : opw

  task automatic go(input logic [31:0] w, input logic pm);
    int n;
    wr(ctu_pkg::CTU_IDX_OP, w);
    wr(ctu_pkg::CTU_IDX_CTRL, {30'h00000000, pm, 1'h1});
    for (n = 0; busy_o !== 1'h1 && n < 4; n++) @(posedge sys_clk_i);
    for (n = 0; busy_o !== 1'h0 && n < 2000; n++) @(posedge sys_clk_i);
  endtask : go

  task automatic st(input logic [15:0] ip, cs, sp);
    chk(32'(instruction_pointer_o), 32'(ip));
    chk(32'(code_seg_o), 32'(cs));
    chk(32'(stack_top_pointer_o), 32'(sp));
  endtask : st

  task automatic pre(input logic [15:0] a, input logic [15:0] d);
    ctu_mem_model_i.mem[a[15:1]] = d;
  endtask : pre

  function automatic logic [31:0] rdm(input logic [15:0] a);
    return {16'h0000, ctu_mem_model_i.mem[a[15:1]]};
  endfunction : rdm

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'h1;
    rdr(ctu_pkg::CTU_IDX_IPCS);
    chk(rd, 32'h0000_0000);
    rdr(ctu_pkg::CTU_IDX_STATUS);
    chk(rd, 32'h0000_0000);
    rdr(4'hC);
    chk(rd, ctu_pkg::CTU_UNMAPPED);
    wr(ctu_pkg::CTU_IDX_IPCS, 32'hFFFF_FFFF);
    rdr(ctu_pkg::CTU_IDX_IPCS);
    chk(rd, 32'h0000_0000);
    wc0 = ctu_mem_model_i.wr_cnt;
    wr(ctu_pkg::CTU_IDX_DISP, 32'h0000_1234);
    go(opw(ctu_pkg::CTU_OP_JMP_REL, 2'h0, 1'h1), 1'h0);
    st(16'h1234, 16'h0000, 16'h0000);
    wr(ctu_pkg::CTU_IDX_DISP, 32'h0000_AAF0);
    go(opw(ctu_pkg::CTU_OP_JMP_REL, 2'h0, 1'h1) | 32'h0000_0010, 1'h0);
    st(16'h1224, 16'h0000, 16'h0000);
    wr(ctu_pkg::CTU_IDX_REGVAL, 32'h0000_4321);
    go(opw(ctu_pkg::CTU_OP_JMP_REG, 2'h0, 1'h1), 1'h0);
    st(16'h4321, 16'h0000, 16'h0000);
    pre(16'h0100, 16'hBEEF);
    wr(ctu_pkg::CTU_IDX_MEMADDR, 32'h0000_0100);
    lat <= 4'h3;
    go(opw(ctu_pkg::CTU_OP_JMP_MEM, 2'h0, 1'h1), 1'h0);
    st(16'hBEEF, 16'h0000, 16'h0000);
    wr(ctu_pkg::CTU_IDX_FAR, 32'h0030_5000);
    go(opw(ctu_pkg::CTU_OP_JMP_FAR_DIR, 2'h0, 1'h1), 1'h0);
    st(16'h5000, 16'h0030, 16'h0000);
    chk(ctu_mem_model_i.wr_cnt, wc0);
    wr(ctu_pkg::CTU_IDX_FAR, 32'h0040_6000);
    go(opw(ctu_pkg::CTU_OP_JMP_FAR_DIR, 2'h0, 1'h0), 1'h0);
    st(16'h5000, 16'h0030, 16'h0000);
    rdr(ctu_pkg::CTU_IDX_STATUS);
    chk({31'h00000000, rd[ctu_pkg::CTU_ST_FAULT_BIT]}, 32'h0000_0001);
    pre(16'h0200, 16'h1111);
    pre(16'h0202, 16'h0050);
    wr(ctu_pkg::CTU_IDX_MEMADDR, 32'h0000_0200);
    go(opw(ctu_pkg::CTU_OP_JMP_FAR_MEM, 2'h0, 1'h1), 1'h0);
    st(16'h1111, 16'h0050, 16'h0000);
    wr(ctu_pkg::CTU_IDX_GATE, 32'h0060_7000);
    wr(ctu_pkg::CTU_IDX_FAR, 32'h0070_9999);
    go(opw(ctu_pkg::CTU_OP_JMP_FAR_DIR, 2'h1, 1'h1), 1'h0);
    st(16'h1111, 16'h0050, 16'h0000);
    go(opw(ctu_pkg::CTU_OP_JMP_FAR_DIR, 2'h1, 1'h1), 1'h1);
    st(16'h7000, 16'h0060, 16'h0000);
    wr(ctu_pkg::CTU_IDX_TASK, 32'h0080_2222);
    for (i = 1; i < 4; i++)
    begin
      go(opw(ctu_pkg::CTU_OP_JMP_FAR_MEM, 2'(i), 1'h1), 1'h1);
      tgt = i == 1 ? 16'h0060 : 16'h0080;
      chk(32'(code_seg_o), 32'(tgt));
    end
    wr(ctu_pkg::CTU_IDX_DISP, 32'h0000_0010);
    wr(ctu_pkg::CTU_IDX_REGVAL, 32'h0000_4444);
    wr(ctu_pkg::CTU_IDX_MEMADDR, 32'h0000_0100);
    for (i = 0; i < 3; i++)
    begin
      ip0 = instruction_pointer_o;
      cs0 = code_seg_o;
      sp0 = stack_top_pointer_o;
      lat <= 4'(2 * i);
      op = i == 0 ? ctu_pkg::CTU_OP_CALL_REL : i == 1 ?
        ctu_pkg::CTU_OP_CALL_REG : ctu_pkg::CTU_OP_CALL_MEM;
      tgt = i == 0 ? ip0 + 16'h0010 : i == 1 ? 16'h4444 : 16'hBEEF;
      go(opw(op, 2'h0, 1'h1), 1'h1);
      st(tgt, cs0, sp0 - 16'h0002);
      chk(rdm(sp0 - 16'h0002), {16'h0000, ip0});
      wr(ctu_pkg::CTU_IDX_SP, 32'h0000_0000);
      go(opw(ctu_pkg::CTU_OP_RET_NEAR, 2'h0, 1'h1), 1'h1);
      st(ip0, cs0, sp0);
    end
    ip0 = instruction_pointer_o;
    cs0 = code_seg_o;
    sp0 = stack_top_pointer_o;
    wr(ctu_pkg::CTU_IDX_FAR, 32'h0090_3000);
    go(opw(ctu_pkg::CTU_OP_CALL_FAR_DIR, 2'h0, 1'h1), 1'h1);
    st(16'h3000, 16'h0090, sp0 - 16'h0004);
    chk(rdm(sp0 - 16'h0002), {16'h0000, cs0});
    chk(rdm(sp0 - 16'h0004), {16'h0000, ip0});
    wr(ctu_pkg::CTU_IDX_SP, 32'h0004_0000);
    go(opw(ctu_pkg::CTU_OP_RET_FAR, 2'h0, 1'h1), 1'h1);
    st(ip0, cs0, sp0 + 16'h0004);
    cs0 = code_seg_o;
    wr(ctu_pkg::CTU_IDX_TASK, 32'h00A0_0ABC);
    go(opw(ctu_pkg::CTU_OP_CALL_FAR_DIR, 2'h3, 1'h1), 1'h1);
    chk(32'(code_seg_o), 32'h0000_00A0);
    chk({31'h00000000, nested_task_flag_o}, 32'h0000_0001);
    rdr(ctu_pkg::CTU_IDX_LINK);
    chk(rd, {16'h0000, cs0});
    sp0 = stack_top_pointer_o;
    go(opw(ctu_pkg::CTU_OP_INTERRUPT_RETURN, 2'h0, 1'h1), 1'h1);
    chk(32'(code_seg_o), 32'(cs0));
    chk(32'(stack_top_pointer_o), 32'(sp0));
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_top

bind ctu_core ctu_core_asserts ctu_core_asserts_i (.sys_clk_i, .nrst_i,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o, .mem_addr_o, .mem_wdata_o,
  .mem_rd_o, .mem_wr_o, .mem_ack_i, .instruction_pointer_o, .code_seg_o,
  .stack_top_pointer_o, .nested_task_flag_o, .busy_o);
`default_nettype wire
